/* rtl/mfi_pkg.sv */
// Constants and types for the motor fault and idle monitor
//
// Overview of operation
// - Short detected: switch output stage off immediately
// - Wait latch timer 256 us, retry once
// - Short persists: off, latch standby, assert fault
// - Latch cleared only by standby control low or by reset
// - Idle output active after full step-free timeout
// - Idle output released at next step edge
// - Idle timeout is a configurable cycle count
// - Idle output open-drain, never drives high
package mfi_pkg;

	localparam int CLK_MHZ = 125;
	localparam int LATCH_TIME_US = 256;
	localparam int LATCH_CYCLES = LATCH_TIME_US * CLK_MHZ;
	localparam int LATCH_CNT_W = 16;
	localparam logic [LATCH_CNT_W-1:0] LATCH_CNT_LAST = LATCH_CNT_W'(LATCH_CYCLES - 1);

	// Idle timeout count, default 0.6 s at 125 MHz (1500 pF)
	localparam int IDLE_CNT_W = 32;
	localparam logic [IDLE_CNT_W-1:0] IDLE_CYCLES_DEF = 32'h0478_68c0;

	typedef enum logic [2:0] {
		MFI_RUN = 3'b000,
		MFI_OFF_WAIT = 3'b001,
		MFI_RETRY = 3'b010,
		MFI_LATCHED = 3'b011
	} mfi_prot_state_t;

endpackage

/* rtl/mfi_idle_if.sv */
// Interface between the monitor and its idle timer
`timescale 1ns/1ns
`default_nettype none
interface mfi_idle_if;
	logic step_edge;
	logic [mfi_pkg::IDLE_CNT_W-1:0] timeout;
	logic idle;
	modport timer (input step_edge, input timeout, output idle);
	modport ctrl (output step_edge, output timeout, input idle);
endinterface
`default_nettype wire

/* rtl/mfi_idle_timer.sv */
// Step idle timer
`timescale 1ns/1ns
`default_nettype none
module mfi_idle_timer import mfi_pkg::*; (
	input wire logic clk,
	input wire logic resetn,
	mfi_idle_if.timer bus
);
	logic [IDLE_CNT_W-1:0] cnt_q;
	logic idle_q;
	wire expired = (cnt_q >= bus.timeout - 32'h0000_0001);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_q <= '0;
			idle_q <= 1'b0;
		end else if (bus.step_edge) begin
			cnt_q <= '0;
			idle_q <= 1'b0;
		end else if (!idle_q) begin
			if (expired) begin
				idle_q <= 1'b1;
			end else begin
				cnt_q <= cnt_q + 32'h0000_0001;
			end
		end
	end

	assign bus.idle = idle_q;
endmodule
`default_nettype wire

/* rtl/mfi_monitor.sv */
// Short protection and step idle monitor top
`timescale 1ns/1ns
`default_nettype none
module mfi_monitor import mfi_pkg::*; #(
	parameter logic [IDLE_CNT_W-1:0] IDLE_CYCLES = IDLE_CYCLES_DEF
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic short_det_in,
	input wire logic standby_ctrl_in,
	input wire logic step_in,
	output logic out_enable,
	output logic fault_flag_out,
	output logic idle_out_o,
	output logic idle_out_oe
);
	logic [1:0] short_sync_q;
	logic [1:0] stby_sync_q;
	logic [1:0] step_sync_q;
	logic step_prev_q;
	mfi_prot_state_t state_q;
	mfi_prot_state_t state_d;
	logic [LATCH_CNT_W-1:0] tmr_q;
	logic out_en_q;
	logic fault_q;
	logic idle_oe_q;
	mfi_idle_if idle_bus ();

	wire short_s = short_sync_q[1];
	// Low level on standby input releases the latch
	wire stby_low = !stby_sync_q[1];
	wire step_rise = step_sync_q[1] & !step_prev_q;
	wire tmr_done = (tmr_q == LATCH_CNT_LAST);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			short_sync_q <= 2'h0;
			stby_sync_q <= 2'h3;
			step_sync_q <= 2'h0;
			step_prev_q <= 1'b0;
		end else begin
			short_sync_q <= {short_sync_q[0], short_det_in};
			stby_sync_q <= {stby_sync_q[0], standby_ctrl_in};
			step_sync_q <= {step_sync_q[0], step_in};
			step_prev_q <= step_sync_q[1];
		end
	end

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			MFI_RUN: begin
				if (short_s) begin
					state_d = MFI_OFF_WAIT;
				end
			end
			MFI_OFF_WAIT: begin
				if (tmr_done) begin
					state_d = MFI_RETRY;
				end
			end
			MFI_RETRY: begin
				if (short_s) begin
					state_d = MFI_LATCHED;
				end else begin
					state_d = MFI_RUN;
				end
			end
			MFI_LATCHED: begin
				if (stby_low) begin
					state_d = MFI_RUN;
				end
			end
			default: state_d = MFI_LATCHED;
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= MFI_RUN;
			tmr_q <= '0;
		end else begin
			state_q <= state_d;
			tmr_q <= (state_q == MFI_OFF_WAIT && !tmr_done) ? tmr_q + 16'h0001 : '0;
		end
	end

	// Out-enable and fault registered from the next state so they follow it directly; idle enable registered from the idle timer
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			out_en_q <= 1'b1;
			fault_q <= 1'b0;
			idle_oe_q <= 1'b0;
		end else begin
			out_en_q <= (state_d == MFI_RUN) || (state_d == MFI_RETRY);
			fault_q <= (state_d == MFI_LATCHED);
			idle_oe_q <= idle_bus.idle && !step_rise;
		end
	end

	assign idle_bus.step_edge = step_rise;
	assign idle_bus.timeout = IDLE_CYCLES;

	mfi_idle_timer u_idle (
		.clk(clk),
		.resetn(resetn),
		.bus(idle_bus)
	);

	assign out_enable = out_en_q;
	assign fault_flag_out = fault_q;
	assign idle_out_o = 1'b0;
	assign idle_out_oe = idle_oe_q;
endmodule
`default_nettype wire

/* verif/mfi_ctl_model.sv */
// Controller model giving step pulses
`timescale 1ns/1ns
`default_nettype none
module mfi_ctl_model (
	input wire logic clk,
	input wire logic [7:0] gap,
	output var logic step = 1'b0
);
	logic [7:0] cnt_q = 8'h00;
	always_ff @(posedge clk) begin
		cnt_q <= (cnt_q >= gap) ? 8'h01 : cnt_q + 8'h01;
		step <= gap != 8'h00 && cnt_q == 8'h01;
	end
endmodule
`default_nettype wire

/* verif/mfi_monitor_chk.sv */
// Port assertions for the monitor
`timescale 1ns/1ns
`default_nettype none
module mfi_monitor_chk import mfi_pkg::*; #(
	parameter logic [IDLE_CNT_W-1:0] IDLE_CYCLES = IDLE_CYCLES_DEF
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic short_det_in,
	input wire logic standby_ctrl_in,
	input wire logic step_in,
	input wire logic out_enable,
	input wire logic fault_flag_out,
	input wire logic idle_out_o,
	input wire logic idle_out_oe
);
	logic [IDLE_CNT_W-1:0] gap_q;
	logic step_q;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			gap_q <= '1;
			step_q <= 1'b1;
		end else begin
			gap_q <= (step_in && !step_q) ? '0 : gap_q + IDLE_CNT_W'(gap_q != '1);
			step_q <= step_in;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	a_short_off: assert property ($rose(short_det_in) && out_enable |-> ##[1:3] !out_enable) else $error("on");
	a_retry_once: assert property ($rose(fault_flag_out) |-> $past(out_enable)) else $error("retry");
	a_fault_off: assert property (fault_flag_out |-> !out_enable) else $error("off");
	a_latch_held: assert property (standby_ctrl_in[*3] ##0 fault_flag_out |=> fault_flag_out) else $error("held");
	a_latch_clear: assert property (!standby_ctrl_in[*5] |-> !fault_flag_out) else $error("clr");
	a_idle_quiet: assert property (gap_q >= 4 && gap_q < IDLE_CYCLES |-> !idle_out_oe) else $error("quiet");
	a_idle_late: assert property (gap_q == IDLE_CYCLES + 6 |-> idle_out_oe) else $error("late");
	a_drain_only: assert property (idle_out_oe |-> !idle_out_o) else $error("od");
	c_fault: cover property ($rose(fault_flag_out));
	c_clear: cover property ($fell(fault_flag_out));
	c_idle: cover property ($rose(idle_out_oe));
endmodule
bind mfi_monitor mfi_monitor_chk #(.IDLE_CYCLES(IDLE_CYCLES)) u_mfi_monitor_chk (.*);
`default_nettype wire

/* verif/mfi_monitor_tb.sv */
// Self-checking bench for the monitor
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_errors++; $display("unexpected %0t bad", $time); end end
module mfi_monitor_tb;
	logic clk = 1'b0, resetn = 1'b0, short_det_in = 1'b0, standby_ctrl_in = 1'b1;
	logic out_enable, fault_flag_out, idle_out_o, idle_out_oe, step_in;
	logic [7:0] gap = 8'h00;
	logic [1:0] exp_q[$];
	logic [1:0] seen = 2'b00;
	int n_errors = 0, comparisons = 0, cyc = 0;
	mfi_ctl_model u_mfi_ctl_model (.clk(clk), .gap(gap), .step(step_in));
	mfi_monitor #(.IDLE_CYCLES(32'h32)) u_mfi_monitor (.clk(clk), .resetn(resetn), .short_det_in(short_det_in),
		.standby_ctrl_in(standby_ctrl_in), .step_in(step_in), .out_enable(out_enable),
		.fault_flag_out(fault_flag_out), .idle_out_o(idle_out_o), .idle_out_oe(idle_out_oe));
	initial begin
		forever #4 clk = ~clk;
	end
	task automatic conclude();
		$display("comparisons %0d errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic wc(input int n);
		repeat (n) @(posedge clk);
	endtask
	always @(negedge clk) begin
		cyc++;
		if (cyc > 90000) begin
			n_errors++;
			conclude();
		end
		if ({fault_flag_out, idle_out_oe} !== seen) begin
			seen = {fault_flag_out, idle_out_oe};
			`CHK(exp_q.size() > 0 ? exp_q.pop_front() : 2'bxx, seen)
			`CHK(idle_out_o, 1'b0)
		end
	end
	initial begin
		void'($urandom(74261));
		wc(4);
		resetn <= 1'b1;
		gap <= 8'($urandom % 30 + 10);
		wc(200);
		exp_q.push_back(2'b01);
		gap <= 8'h00;
		wc(100);
		exp_q.push_back(2'b00);
		gap <= 8'h0c;
		wc(100);
		$display("idle test end");
		short_det_in <= 1'b1;
		wc(20);
		@(negedge clk) `CHK(out_enable, 1'b0)
		wc(1);
		short_det_in <= 1'b0;
		wc(33000);
		@(negedge clk) `CHK(out_enable, 1'b1)
		$display("retry test end");
		exp_q.push_back(2'b10);
		wc(1);
		short_det_in <= 1'b1;
		wc(33000);
		short_det_in <= 1'b0;
		wc(50);
		exp_q.push_back(2'b00);
		standby_ctrl_in <= 1'b0;
		wc(10);
		standby_ctrl_in <= 1'b1;
		wc(10);
		`CHK(exp_q.size(), 0)
		$display("latch test end");
		conclude();
	end
endmodule
`default_nettype wire
